// ==== src/dtm_timer.sv ====
// Dual timer/counter with mode register, control register and interrupt status.
// Assumes a single-cycle register port and asynchronous count and gate pins.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "dtm_defines.svh"
module dtm_timer (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Interrupt service entry, one-cycle pulses from the core
   input wire logic a_isr_ack_i,
   input wire logic b_isr_ack_i,
   // External pins
   input wire logic timer_a_count_pin_i,
   input wire logic timer_b_count_pin_i,
   input wire logic timer_a_gate_pin_i,
   input wire logic timer_b_gate_pin_i,
   // Interrupt and overflow flags
   output logic irq_o,
   output logic timer_a_overflow_flag_o,
   output logic timer_b_overflow_flag_o
);
   import dtm_pkg::*;

   // Mode register and the four counter bytes
   logic [7:0] mode_reg, mode_next;
   logic [7:0] a_low_reg, a_low_next, a_high_reg, a_high_next;
   logic [7:0] b_low_reg, b_low_next, b_high_reg, b_high_next;
   // Run and overflow bits of the control register
   logic a_run_reg, a_run_next, b_run_reg, b_run_next;
   logic a_ovf_reg, a_ovf_next, b_ovf_reg, b_ovf_next;
   // Interrupt status and enable, read data and the registered request
   logic [1:0] irq_stat_reg, irq_stat_next, irq_en_reg, irq_en_next;
   logic [7:0] rdata_reg, rdata_next;
   logic irq_reg, irq_next;
   // Tick divider and per-pin synchroniser results
   logic [2:0] div_reg, div_next;
   logic tick;
   logic [3:0] pin_lvl, pin_rise;
   // Per-cycle increment decisions and overflow events
   logic a_gate_ok, b_gate_ok, a_inc, b_inc;
   logic ovf_a_evt, ovf_b_evt;
   dtm_mode_t a_mode, b_mode;

   ////////////////////////////////////////////////////////////////
   // Pin synchronisers: count pins use edges, gate pins use levels
   // One synchroniser per pin; the gate edges and count levels are simply left unused
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         logic pin_raw;
         if (gi == 0) begin : g0
            assign pin_raw = timer_a_count_pin_i;
         end else if (gi == 1) begin : g1
            assign pin_raw = timer_b_count_pin_i;
         end else if (gi == 2) begin : g2
            assign pin_raw = timer_a_gate_pin_i;
         end else begin : g3
            assign pin_raw = timer_b_gate_pin_i;
         end
         dtm_pin_sync u_sync (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .pin_i(pin_raw),
            .level_o(pin_lvl[gi]),
            .rise_o(pin_rise[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////
   // Tick divider: the timer resolution is slower than the core clock
   always_comb begin
      // Free-running: the first tick after a run comes within eight clocks, not at once
      tick = (div_reg == 3'(`DTM_TICK_DIV - 1));
      div_next = tick ? 3'h0 : div_reg + 3'h1;
   end

   ////////////////////////////////////////////////////////////////
   // Increment enables from gating and source selection
   always_comb begin
      a_mode = dtm_mode_t'(mode_reg[`DTM_FLD_A_MODE]);
      b_mode = dtm_mode_t'(mode_reg[`DTM_FLD_B_MODE]);
      // A closed gate or a cleared run bit freezes the count but keeps its value
      a_gate_ok = a_run_reg && (!mode_reg[`DTM_BIT_A_GATING] || pin_lvl[2]);
      b_gate_ok = b_run_reg && (!mode_reg[`DTM_BIT_B_GATING] || pin_lvl[3]);
      a_inc = a_gate_ok && (mode_reg[`DTM_BIT_A_SOURCE] ? pin_rise[0] : tick);
      b_inc = b_gate_ok && (mode_reg[`DTM_BIT_B_SOURCE] ? pin_rise[1] : tick);
   end

   ////////////////////////////////////////////////////////////////
   // Counter datapath for both timers
   always_comb begin
      a_low_next = a_low_reg;
      a_high_next = a_high_reg;
      b_low_next = b_low_reg;
      b_high_next = b_high_reg;
      ovf_a_evt = 1'b0;
      ovf_b_evt = 1'b0;
      // Timer A
      if (a_inc) begin
         case (a_mode)
            // Low five bits prescale; bits 7:5 stay zero so reads show only the prescaler
            DTM_MODE_13BIT: begin
               a_low_next = {3'h0, a_low_reg[4:0] + 5'h01};
               if (a_low_reg[4:0] == 5'h1F) begin
                  a_high_next = a_high_reg + 8'h01;
                  ovf_a_evt = (a_high_reg == 8'hFF);
               end
            end
            // Carry from the low byte into the high byte
            DTM_MODE_16BIT: begin
               a_low_next = a_low_reg + 8'h01;
               if (a_low_reg == 8'hFF) begin
                  a_high_next = a_high_reg + 8'h01;
                  ovf_a_evt = (a_high_reg == 8'hFF);
               end
            end
            // The high byte is only a reload value here and never counts
            DTM_MODE_RELOAD: begin
               a_low_next = (a_low_reg == 8'hFF) ? a_high_reg : a_low_reg + 8'h01;
               ovf_a_evt = (a_low_reg == 8'hFF);
            end
            // Split: this is the low half, on timer A controls
            default: begin
               a_low_next = a_low_reg + 8'h01;
               ovf_a_evt = (a_low_reg == 8'hFF);
            end
         endcase
      end
      // Split mode: high half of A runs on timer B controls
      if (a_mode == DTM_MODE_SPLIT && b_inc) begin
         a_high_next = a_high_reg + 8'h01;
         ovf_b_evt = (a_high_reg == 8'hFF);
      end else if (b_inc && b_mode != DTM_MODE_SPLIT) begin
         case (b_mode)
            // Same encoding as timer A
            DTM_MODE_13BIT: begin
               b_low_next = {3'h0, b_low_reg[4:0] + 5'h01};
               if (b_low_reg[4:0] == 5'h1F) begin
                  b_high_next = b_high_reg + 8'h01;
                  ovf_b_evt = (b_high_reg == 8'hFF);
               end
            end
            DTM_MODE_16BIT: begin
               b_low_next = b_low_reg + 8'h01;
               if (b_low_reg == 8'hFF) begin
                  b_high_next = b_high_reg + 8'h01;
                  ovf_b_evt = (b_high_reg == 8'hFF);
               end
            end
            // Reload mode; code 11 never gets here because timer B then holds
            default: begin
               b_low_next = (b_low_reg == 8'hFF) ? b_high_reg : b_low_reg + 8'h01;
               ovf_b_evt = (b_low_reg == 8'hFF);
            end
         endcase
      end
      // Software writes to the data bytes take precedence over counting
      if (wr_i) begin
         case (addr_i)
            `DTM_ADDR_A_LOW: a_low_next = wdata_i;
            `DTM_ADDR_A_HIGH: a_high_next = wdata_i;
            `DTM_ADDR_B_LOW: b_low_next = wdata_i;
            `DTM_ADDR_B_HIGH: b_high_next = wdata_i;
            default: ;
         endcase
      end
   end

   // Counter bytes and tick divider
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_low_reg <= 8'h00;
         a_high_reg <= 8'h00;
         b_low_reg <= 8'h00;
         b_high_reg <= 8'h00;
         div_reg <= 3'h0;
      end else begin
         a_low_reg <= a_low_next;
         a_high_reg <= a_high_next;
         b_low_reg <= b_low_next;
         b_high_reg <= b_high_next;
         div_reg <= div_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Mode, control and interrupt registers; hardware set beats any clear
   always_comb begin
      mode_next = mode_reg;
      a_run_next = a_run_reg;
      b_run_next = b_run_reg;
      a_ovf_next = a_ovf_reg;
      b_ovf_next = b_ovf_reg;
      irq_en_next = irq_en_reg;
      irq_stat_next = irq_stat_reg;
      if (wr_i) begin
         case (addr_i)
            `DTM_ADDR_MODE: mode_next = wdata_i;
            `DTM_ADDR_CTRL: begin
               a_run_next = wdata_i[`DTM_CTRL_A_RUN];
               b_run_next = wdata_i[`DTM_CTRL_B_RUN];
               a_ovf_next = wdata_i[`DTM_CTRL_A_OVF];
               b_ovf_next = wdata_i[`DTM_CTRL_B_OVF];
            end
            `DTM_ADDR_IRQ_EN: irq_en_next = wdata_i[1:0];
            `DTM_ADDR_IRQ_CLR: irq_stat_next = irq_stat_reg & ~wdata_i[1:0];
            default: ;
         endcase
      end
      // Service entry clears first, so an overflow in the same cycle still sets the flag
      if (a_isr_ack_i) begin
         a_ovf_next = 1'b0;
      end
      if (b_isr_ack_i) begin
         b_ovf_next = 1'b0;
      end
      if (ovf_a_evt) begin
         a_ovf_next = 1'b1;
         irq_stat_next[0] = 1'b1;
      end
      if (ovf_b_evt) begin
         b_ovf_next = 1'b1;
         irq_stat_next[1] = 1'b1;
      end
      // Taken from the next values so the request follows status with no extra cycle
      irq_next = |(irq_stat_next & irq_en_next);
   end

   // Register stage for mode, control and interrupt state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_reg <= `DTM_MODE_RESET;
         a_run_reg <= 1'b0;
         b_run_reg <= 1'b0;
         a_ovf_reg <= 1'b0;
         b_ovf_reg <= 1'b0;
         irq_en_reg <= 2'h0;
         irq_stat_reg <= 2'h0;
         irq_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         a_run_reg <= a_run_next;
         b_run_reg <= b_run_next;
         a_ovf_reg <= a_ovf_next;
         b_ovf_reg <= b_ovf_next;
         irq_en_reg <= irq_en_next;
         irq_stat_reg <= irq_stat_next;
         irq_reg <= irq_next;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read data, valid the cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_next = 8'h00;
      if (rd_i) begin
         case (addr_i)
            `DTM_ADDR_MODE: rdata_next = mode_reg;
            `DTM_ADDR_A_LOW: rdata_next = a_low_reg;
            `DTM_ADDR_A_HIGH: rdata_next = a_high_reg;
            `DTM_ADDR_B_LOW: rdata_next = b_low_reg;
            `DTM_ADDR_B_HIGH: rdata_next = b_high_reg;
            `DTM_ADDR_CTRL: rdata_next = {b_ovf_reg, b_run_reg, a_ovf_reg, a_run_reg, 4'h0};
            `DTM_ADDR_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
            `DTM_ADDR_IRQ_EN: rdata_next = {6'h00, irq_en_reg};
            default: rdata_next = 8'h00;
         endcase
      end
   end

   // Registered so the read data come straight from a flip-flop
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Every output is a flip-flop output, no logic after the registers
   assign rdata_o = rdata_reg;
   assign irq_o = irq_reg;
   assign timer_a_overflow_flag_o = a_ovf_reg;
   assign timer_b_overflow_flag_o = b_ovf_reg;
endmodule

// ==== src/dtm_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the dual timer block.
// Assumes nothing; definitions only.
`ifndef DTM_DEFINES_SVH
`define DTM_DEFINES_SVH
`define DTM_ADDR_MODE 8'h89
`define DTM_ADDR_A_LOW 8'h8A
`define DTM_ADDR_B_LOW 8'h8B
`define DTM_ADDR_A_HIGH 8'h8C
`define DTM_ADDR_B_HIGH 8'h8D
`define DTM_ADDR_CTRL 8'h88
`define DTM_ADDR_IRQ_STAT 8'h90
`define DTM_ADDR_IRQ_EN 8'h91
`define DTM_ADDR_IRQ_CLR 8'h92
`define DTM_MODE_RESET 8'h00
`define DTM_BIT_B_GATING 7
`define DTM_BIT_B_SOURCE 6
`define DTM_BIT_A_GATING 3
`define DTM_BIT_A_SOURCE 2
`define DTM_FLD_B_MODE 5:4
`define DTM_FLD_A_MODE 1:0
`define DTM_CTRL_B_OVF 7
`define DTM_CTRL_B_RUN 6
`define DTM_CTRL_A_OVF 5
`define DTM_CTRL_A_RUN 4
`define DTM_SYS_HZ 40000000
`define DTM_TICK_HZ 5000000
`define DTM_TICK_DIV (`DTM_SYS_HZ / `DTM_TICK_HZ)
`endif

// ==== src/dtm_pkg.sv ====
// Types shared by the dual timer block.
// Assumes the defines header for numeric constants.
package dtm_pkg;
   typedef enum logic [1:0] {
      DTM_MODE_13BIT = 2'b00,
      DTM_MODE_16BIT = 2'b01,
      DTM_MODE_RELOAD = 2'b10,
      DTM_MODE_SPLIT = 2'b11
   } dtm_mode_t;
   typedef enum logic [0:0] {
      DTM_EDGE_IDLE = 1'b0,
      DTM_EDGE_HIGH = 1'b1
   } dtm_edge_t;
endpackage

// ==== src/dtm_pin_sync.sv ====
// Two-stage synchroniser with rising-edge detector for one external pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/1ps
module dtm_pin_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin and results
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o
);
   import dtm_pkg::*;
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   dtm_edge_t last_reg, last_next;

   ////////////////////////////////////////////////////////////////
   // Next values; the first stage feeds only the second
   always_comb begin
      meta_next = pin_i;
      sync_next = meta_reg;
      case (sync_reg)
         1'b1: last_next = DTM_EDGE_HIGH;
         default: last_next = DTM_EDGE_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= DTM_EDGE_IDLE;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         last_reg <= last_next;
      end
   end

   assign level_o = sync_reg;
   assign rise_o = sync_reg && (last_reg == DTM_EDGE_IDLE);
endmodule

// ==== verification/dtm_pin_model.sv ====
// Far-side model of the external count and gate pins.
// Assumes the timer synchronises the pins itself, so pins change off the clock.
`timescale 1ns/1ps
module dtm_pin_model (
   // Pins toward the timer
   output logic timer_a_count_pin_o,
   output logic timer_b_count_pin_o,
   output logic timer_a_gate_pin_o,
   output logic timer_b_gate_pin_o
);
   // Count pins idle low and gates start closed
   initial begin
      timer_a_count_pin_o = 1'b0;
      timer_b_count_pin_o = 1'b0;
      timer_a_gate_pin_o = 1'b0;
      timer_b_gate_pin_o = 1'b0;
   end
   // Each level lasts over three clocks so the two-flop sync cannot miss it
   task automatic burst(input logic b, input int n);
      for (int i = 0; i < n; i++) begin
         #83;
         if (b) timer_b_count_pin_o = 1'b1;
         else timer_a_count_pin_o = 1'b1;
         #91;
         timer_a_count_pin_o = 1'b0;
         timer_b_count_pin_o = 1'b0;
      end
   endtask
   // Both gates move together
   task automatic set_gate(input logic g);
      timer_a_gate_pin_o = g;
      timer_b_gate_pin_o = g;
   endtask
endmodule

// ==== verification/dtm_timer_assertions.sv ====
// Port-level checks of the dual timer, bound into every instance.
// Assumes one clock domain and the register map of the defines header.
`timescale 1ns/1ps
`include "dtm_defines.svh"
module dtm_timer_checker (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Service entry, pins and flags
   input wire logic a_isr_ack_i,
   input wire logic b_isr_ack_i,
   input wire logic timer_a_gate_pin_i,
   input wire logic timer_b_gate_pin_i,
   input wire logic timer_a_overflow_flag_o,
   input wire logic timer_b_overflow_flag_o
);
   logic [7:0] mode_reg, mode_next, run_reg, run_next;
   logic [9:0] gate_reg, gate_next;
   ////////////////////////////////////////
   // Shadow of mode, four cycles of run bits {B,A}, five of each gate pin
   always_comb begin
      mode_next = (wr_i && addr_i == `DTM_ADDR_MODE) ? wdata_i : mode_reg;
      run_next = {run_reg[5:0], run_reg[1:0]};
      if (wr_i && addr_i == `DTM_ADDR_CTRL) run_next[1:0] = {wdata_i[`DTM_CTRL_B_RUN], wdata_i[`DTM_CTRL_A_RUN]};
      gate_next = {gate_reg[8:5], timer_b_gate_pin_i, gate_reg[3:0], timer_a_gate_pin_i};
   end
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_reg <= `DTM_MODE_RESET;
         run_reg <= 8'h00;
         gate_reg <= 10'h000;
      end else begin
         mode_reg <= mode_next;
         run_reg <= run_next;
         gate_reg <= gate_next;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Read data only in the cycle after a read
   a_idle_rdata: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data outside a read");
   a_mode_read: assert property (rd_i && addr_i == `DTM_ADDR_MODE |=> rdata_o == $past(mode_reg))
      else $error("mode register read back wrong");
   a_unmapped_read: assert property (rd_i && !(addr_i inside {[8'h88:8'h8D], [8'h90:8'h92]}) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   // A natural overflow needs the run bit and, when gating is on, an open gate
   a_a_run_gate: assert property ($rose(timer_a_overflow_flag_o) && !$past(wr_i) |->
      (run_reg[2] | run_reg[4] | run_reg[6]) && (!mode_reg[`DTM_BIT_A_GATING] || |gate_reg[4:0]))
      else $error("timer A overflowed while stopped or gated");
   a_b_run_gate: assert property ($rose(timer_b_overflow_flag_o) && !$past(wr_i) |->
      (run_reg[3] | run_reg[5] | run_reg[7]) && (!mode_reg[`DTM_BIT_B_GATING] || |gate_reg[9:5]))
      else $error("timer B overflowed while stopped or gated");
   // Service entry clears a flag that no overflow can set again
   a_a_ack_clear: assert property (a_isr_ack_i && !wr_i && !(run_reg[0] | run_reg[2] | run_reg[4])
      |=> !timer_a_overflow_flag_o) else $error("timer A flag kept after service entry");
   a_b_ack_clear: assert property (b_isr_ack_i && !wr_i && !(run_reg[1] | run_reg[3] | run_reg[5])
      |=> !timer_b_overflow_flag_o) else $error("timer B flag kept after service entry");
   a_a_flag_hold: assert property (timer_a_overflow_flag_o && !a_isr_ack_i && !wr_i |=> timer_a_overflow_flag_o)
      else $error("timer A flag dropped on its own");
   a_b_flag_hold: assert property (timer_b_overflow_flag_o && !b_isr_ack_i && !wr_i |=> timer_b_overflow_flag_o)
      else $error("timer B flag dropped on its own");
endmodule
bind dtm_timer dtm_timer_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .a_isr_ack_i(a_isr_ack_i), .b_isr_ack_i(b_isr_ack_i),
   .timer_a_gate_pin_i(timer_a_gate_pin_i), .timer_b_gate_pin_i(timer_b_gate_pin_i),
   .timer_a_overflow_flag_o(timer_a_overflow_flag_o), .timer_b_overflow_flag_o(timer_b_overflow_flag_o));

// ==== verification/test_dual_timer_mode_control.sv ====
// Self-checking bench: registers, modes, gating, sources, split mode, interrupt.
// Assumes the pin model and the checker are compiled before it.
`timescale 1ns/1ps
`include "dtm_defines.svh"
module test_dual_timer_mode_control;
   import dtm_pkg::*;
   logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
   logic a_isr_ack_i = 1'b0, b_isr_ack_i = 1'b0, irq_o, fa, fb, ca, cb, ga, gb;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
   logic [7:0] exp_q[$];
   int err_count = 0, checks_done = 0;
   always #12.5 clk_i = ~clk_i;
   dtm_timer dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .a_isr_ack_i(a_isr_ack_i), .b_isr_ack_i(b_isr_ack_i), .timer_a_count_pin_i(ca),
      .timer_b_count_pin_i(cb), .timer_a_gate_pin_i(ga), .timer_b_gate_pin_i(gb), .irq_o(irq_o),
      .timer_a_overflow_flag_o(fa), .timer_b_overflow_flag_o(fb));
   dtm_pin_model pin_u (.timer_a_count_pin_o(ca), .timer_b_count_pin_o(cb), .timer_a_gate_pin_o(ga),
      .timer_b_gate_pin_o(gb));
   ////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read data stand only in the cycle after the strobe, so compare there
   always @(posedge clk_i) begin
      if (rd_d) check("read data", rdata_o, exp_q.pop_front());
      rd_d <= rd_i;
   end
   // A gap cycle after each strobe keeps every signal to one assignment per step
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // Preset, run, wait a bounded time for overflow, stop, read low byte, enter service
   task automatic trial(input logic b, input logic [7:0] mode, lo, hi, input int n,
      input logic g, e, input logic [7:0] el);
      logic seen = 1'b0;
      pin_u.set_gate(g);
      bus_wr(`DTM_ADDR_MODE, mode);
      bus_wr(b ? `DTM_ADDR_B_LOW : `DTM_ADDR_A_LOW, lo);
      bus_wr(b ? `DTM_ADDR_B_HIGH : `DTM_ADDR_A_HIGH, hi);
      bus_wr(`DTM_ADDR_CTRL, b ? 8'h40 : 8'h10);
      if (n > 0) pin_u.burst(b, n);
      for (int i = 0; i < 60 && !seen; i++) begin
         @(posedge clk_i);
         seen = b ? fb : fa;
      end
      check("overflow flag", {7'h00, seen}, {7'h00, e});
      // Stopping keeps the flag bit so the service entry is what clears it
      bus_wr(`DTM_ADDR_CTRL, {b & e, 1'b0, ~b & e, 5'h00});
      bus_rd(b ? `DTM_ADDR_B_LOW : `DTM_ADDR_A_LOW, el);
      if (e) begin
         if (b) b_isr_ack_i <= 1'b1;
         else a_isr_ack_i <= 1'b1;
         @(posedge clk_i);
         a_isr_ack_i <= 1'b0;
         b_isr_ack_i <= 1'b0;
         repeat (2) @(posedge clk_i);
         check("flag after service", {7'h00, b ? fb : fa}, 8'h00);
      end
   endtask
   // Hang guard at 16000 cycles, far beyond the several hundred cycles the tests need
   initial begin
      #400000;
      err_count++;
      complete_run();
   end
   initial begin
      logic [7:0] r;
      void'($urandom(32'hdbe20736));
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      r = 8'($urandom);
      bus_rd(`DTM_ADDR_MODE, `DTM_MODE_RESET);
      bus_rd(`DTM_ADDR_CTRL, 8'h00);
      bus_rd(8'hFF, 8'h00);
      bus_wr(`DTM_ADDR_MODE, r);
      bus_rd(`DTM_ADDR_MODE, r);
      trial(1'b0, 8'h00, 8'h1E, 8'hFF, 0, 1'b0, 1'b1, 8'h00);
      trial(1'b0, 8'h01, 8'hFE, 8'hFF, 0, 1'b0, 1'b1, 8'h00);
      trial(1'b0, 8'h02, 8'hFE, r, 0, 1'b0, 1'b1, r);
      trial(1'b0, 8'h0A, 8'hFE, r, 0, 1'b0, 1'b0, 8'hFE);
      trial(1'b0, 8'h06, 8'hFE, r, 0, 1'b1, 1'b0, 8'hFE);
      trial(1'b0, 8'h0E, 8'hFD, r, 3, 1'b1, 1'b1, r);
      trial(1'b1, 8'h20, 8'hFE, r, 0, 1'b0, 1'b1, r);
      trial(1'b1, 8'hE0, 8'hFD, r, 3, 1'b0, 1'b0, 8'hFD);
      trial(1'b1, 8'hE0, 8'hFD, r, 3, 1'b1, 1'b1, r);
      trial(1'b1, 8'h00, 8'h1E, 8'hFF, 0, 1'b0, 1'b1, 8'h00);
      trial(1'b1, 8'h10, 8'hFE, 8'hFF, 0, 1'b0, 1'b1, 8'h00);
      // Timer B given code 11 on its own simply holds
      trial(1'b1, 8'h30, 8'hFE, 8'hFF, 0, 1'b0, 1'b0, 8'hFE);
      // Split: low half on A controls, high half on B controls, B held
      bus_wr(`DTM_ADDR_MODE, 8'h03);
      bus_wr(`DTM_ADDR_A_LOW, 8'hFF);
      bus_wr(`DTM_ADDR_A_HIGH, 8'hFF);
      bus_wr(`DTM_ADDR_B_LOW, 8'h5A);
      bus_wr(`DTM_ADDR_CTRL, 8'h50);
      repeat (20) @(posedge clk_i);
      check("split flags", {6'h00, fb, fa}, 8'h03);
      bus_wr(`DTM_ADDR_CTRL, 8'hA0);
      bus_rd(`DTM_ADDR_B_LOW, 8'h5A);
      // Interrupt: sticky status, masked, raised, cleared
      bus_rd(`DTM_ADDR_IRQ_STAT, 8'h03);
      check("irq masked", {7'h00, irq_o}, 8'h00);
      bus_wr(`DTM_ADDR_IRQ_EN, 8'h02);
      @(posedge clk_i);
      check("irq raised", {7'h00, irq_o}, 8'h01);
      bus_wr(`DTM_ADDR_IRQ_CLR, 8'h03);
      @(posedge clk_i);
      check("irq cleared", {7'h00, irq_o}, 8'h00);
      bus_rd(`DTM_ADDR_IRQ_STAT, 8'h00);
      // Let the monitor take the last read before the verdict
      @(posedge clk_i);
      complete_run();
   end
endmodule
